// ### src/wkcfg_core.sv
`timescale 1ns/1ps
`include "wkcfg_map.svh"
module wkcfg_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wake pins, after the comparator
  input wire logic [2:0] wake_pin,
  // configuration, two pull and two filter bits per input, one source enable bit per input
  input wire logic [5:0] wake_pull_control_reg,
  input wire logic [5:0] wake_filter_control_reg,
  input wire logic [2:0] wake_source_enable_reg,
  input wire logic measurement_enable,
  input wire logic other_wake_source_enabled,
  // operating mode and sleep command
  input wire wkcfg_pkg::wkcfg_mode_t op_mode,
  input wire logic sleep_command,
  // cyclic sense sample windows from the timers
  input wire logic first_timer_on,
  input wire logic second_timer_on,
  // status clear
  input wire logic [2:0] wake_event_clear,
  // outputs
  output logic [2:0] wake_event_status_first,
  output logic [2:0] wake_pin_level_status,
  output logic [2:0] pull_up_enable,
  output logic [2:0] pull_down_enable,
  output logic measurement_switch,
  output logic wake_request,
  output logic spi_fail,
  output logic restart_request,
  output logic sleep_accept
);
  import wkcfg_pkg::*;

  wkcfg_state_t state;
  wkcfg_state_t next_state;

  function automatic wkcfg_cnt_t filt_len(input logic [1:0] code);
    if (code == `WKCFG_FLT_STATIC64) begin
      filt_len = wkcfg_cnt_t'(`WKCFG_FILT_LONG_CYC);
    end else begin
      filt_len = wkcfg_cnt_t'(`WKCFG_FILT_SHORT_CYC);
    end
  endfunction

  function automatic logic sense_on(input logic [1:0] code, input logic t1, input logic t2);
    case (code)
      `WKCFG_FLT_CYCLIC_T1: sense_on = t1;
      `WKCFG_FLT_CYCLIC_T2: sense_on = t2;
      default: sense_on = 1'b1;
    endcase
  endfunction

  always_comb begin
    logic [1:0] pcode;
    logic [1:0] fcode;
    logic gated;
    logic evt;
    logic ok;
    pcode = 2'h0;
    fcode = 2'h0;
    gated = 1'b0;
    evt = 1'b0;
    ok = 1'b0;
    next_state = state;
    next_state.sync1 = wake_pin;
    next_state.sync2 = state.sync1;
    next_state.wake_request = 1'b0;
    next_state.spi_fail = 1'b0;
    next_state.restart = 1'b0;
    next_state.sleep_ok = 1'b0;
    for (int i = 0; i < 3; i++) begin
      pcode = wake_pull_control_reg[2*i +: 2];
      fcode = wake_filter_control_reg[2*i +: 2];
      gated = measurement_enable && (i < 2);
      evt = 1'b0;
      next_state.active[i] = sense_on(fcode, first_timer_on, second_timer_on);
      // cyclic sense only looks while the timer window is open
      if (!next_state.active[i]) begin
        next_state.cnt[i] = '0;
        next_state.cand[i] = state.level[i];
      end else if (state.sync2[i] != state.cand[i]) begin
        next_state.cand[i] = state.sync2[i];
        next_state.cnt[i] = '0;
      end else if (state.cand[i] != state.level[i]) begin
        if (state.cnt[i] >= filt_len(fcode) - wkcfg_cnt_t'(1)) begin
          next_state.level[i] = state.cand[i];
          next_state.cnt[i] = '0;
          evt = 1'b1;
        end else begin
          next_state.cnt[i] = state.cnt[i] + wkcfg_cnt_t'(1);
        end
      end
      if (!gated) begin
        next_state.level_status[i] = next_state.level[i];
      end
      // set wins over clear
      if (wake_event_clear[i]) begin
        next_state.wake_event[i] = 1'b0;
      end
      if (evt && !gated && wake_source_enable_reg[i]) begin
        next_state.wake_event[i] = 1'b1;
        next_state.wake_request = 1'b1;
      end
      if (gated) begin
        next_state.pull_up_en[i] = 1'b0;
        next_state.pull_down_en[i] = 1'b0;
      end else begin
        case (pcode)
          `WKCFG_PULL_DOWN: begin
            next_state.pull_up_en[i] = 1'b0;
            next_state.pull_down_en[i] = 1'b1;
          end
          `WKCFG_PULL_UP: begin
            next_state.pull_up_en[i] = 1'b1;
            next_state.pull_down_en[i] = 1'b0;
          end
          `WKCFG_PULL_AUTO: begin
            next_state.pull_up_en[i] = next_state.level[i];
            next_state.pull_down_en[i] = !next_state.level[i];
          end
          default: begin
            next_state.pull_up_en[i] = 1'b0;
            next_state.pull_down_en[i] = 1'b0;
          end
        endcase
      end
    end
    next_state.switch_closed = measurement_enable && (op_mode == wkcfg_mode_normal);
    if (sleep_command) begin
      ok = other_wake_source_enabled || wake_source_enable_reg[2] ||
           (!measurement_enable && (wake_source_enable_reg[1:0] != 2'h0));
      if (measurement_enable && !ok && (wake_source_enable_reg[1:0] != 2'h0)) begin
        next_state.spi_fail = 1'b1;
        next_state.restart = 1'b1;
      end else begin
        next_state.sleep_ok = 1'b1;
      end
    end
  end

  // pins settle at reset with pulls off, so the level history starts low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign wake_event_status_first = state.wake_event;
  assign wake_pin_level_status = state.level_status;
  assign pull_up_enable = state.pull_up_en;
  assign pull_down_enable = state.pull_down_en;
  assign measurement_switch = state.switch_closed;
  assign wake_request = state.wake_request;
  assign spi_fail = state.spi_fail;
  assign restart_request = state.restart;
  assign sleep_accept = state.sleep_ok;
endmodule // wkcfg_core

// ### src/wkcfg_map.svh
`ifndef WKCFG_MAP_SVH
`define WKCFG_MAP_SVH
// filter field codes
`define WKCFG_FLT_STATIC16 2'h0
`define WKCFG_FLT_STATIC64 2'h1
`define WKCFG_FLT_CYCLIC_T1 2'h2
`define WKCFG_FLT_CYCLIC_T2 2'h3
// pull field codes
`define WKCFG_PULL_NONE 2'h0
`define WKCFG_PULL_DOWN 2'h1
`define WKCFG_PULL_UP 2'h2
`define WKCFG_PULL_AUTO 2'h3
// reset values
`define WKCFG_PULL_RST 6'h00
`define WKCFG_FLT_RST 6'h00
`define WKCFG_MEAS_RST 1'h0
// timing
`define WKCFG_CLK_MHZ 20
`define WKCFG_FILT_SHORT_US 16
`define WKCFG_FILT_LONG_US 64
`define WKCFG_FILT_SHORT_CYC (`WKCFG_FILT_SHORT_US * `WKCFG_CLK_MHZ)
`define WKCFG_FILT_LONG_CYC (`WKCFG_FILT_LONG_US * `WKCFG_CLK_MHZ)
`endif

// ### src/wkcfg_pkg.sv
package wkcfg_pkg;
  typedef enum logic [1:0] {
    wkcfg_mode_normal,
    wkcfg_mode_stop,
    wkcfg_mode_sleep,
    wkcfg_mode_other
  } wkcfg_mode_t;

  typedef logic [11:0] wkcfg_cnt_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] level;
    logic [2:0] cand;
    wkcfg_cnt_t [2:0] cnt;
    logic [2:0] active;
    logic [2:0] wake_event;
    logic [2:0] level_status;
    logic [2:0] pull_up_en;
    logic [2:0] pull_down_en;
    logic switch_closed;
    logic wake_request;
    logic spi_fail;
    logic restart;
    logic sleep_ok;
  } wkcfg_state_t;
endpackage

// ### testbench/wkcfg_properties.sv
`timescale 1ns/1ps
module wkcfg_properties (
  // clock, reset and settings
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] wake_pull_control_reg,
  input wire logic [2:0] wake_source_enable_reg,
  input wire logic measurement_enable,
  input wire logic other_wake_source_enabled,
  input wire wkcfg_pkg::wkcfg_mode_t op_mode,
  input wire logic sleep_command,
  // block outputs
  input wire logic [2:0] pull_up_enable,
  input wire logic [2:0] pull_down_enable,
  input wire logic measurement_switch,
  input wire logic spi_fail,
  input wire logic sleep_accept
);
  import wkcfg_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire [1:0] p2 = wake_pull_control_reg[5:4];
  property p_sw;
    !$past(rst) |-> measurement_switch == $past(measurement_enable && op_mode == wkcfg_mode_normal);
  endproperty
  a_sw: assert property (p_sw) else $error("switch");
  property p_pd; $past(!rst && p2 == 2'h1) |-> pull_down_enable[2] && !pull_up_enable[2]; endproperty
  a_pd: assert property (p_pd) else $error("pull-down");
  property p_pu; $past(!rst && p2 == 2'h2) |-> pull_up_enable[2] && !pull_down_enable[2]; endproperty
  a_pu: assert property (p_pu) else $error("pull-up");
  property p_auto; $past(!rst && p2 == 2'h3) |-> pull_up_enable[2] != pull_down_enable[2]; endproperty
  a_auto: assert property (p_auto) else $error("auto pull");
  property p_off;
    $past(!rst && !measurement_enable && wake_pull_control_reg[1:0] == 2'h0) |-> !pull_up_enable[0] && !pull_down_enable[0];
  endproperty
  a_off: assert property (p_off) else $error("no pull");
  property p_meas; $past(!rst && measurement_enable) |-> (pull_up_enable[1:0] | pull_down_enable[1:0]) == 2'h0; endproperty
  a_meas: assert property (p_meas) else $error("pulls under measurement");
  property p_fail;
    sleep_command && measurement_enable && !other_wake_source_enabled && !wake_source_enable_reg[2]
      && wake_source_enable_reg[1:0] != 2'h0 |=> spi_fail && !sleep_accept;
  endproperty
  a_fail: assert property (p_fail) else $error("sleep not refused");
  property p_ok; sleep_command && !measurement_enable |=> sleep_accept && !spi_fail; endproperty
  a_ok: assert property (p_ok) else $error("sleep refused");
endmodule // wkcfg_properties

// ### testbench/wkcfg_pins.sv
`timescale 1ns/1ps
module wkcfg_pins (
  // bench levels and pull currents
  input wire logic clock,
  input wire logic [2:0] drive,
  input wire logic [2:0] level,
  input wire logic [2:0] pull_up_enable,
  input wire logic [2:0] pull_down_enable,
  // pins
  output logic [2:0] wake_pin
);
  logic [2:0] wobble = 3'h0;
  // an open pin without current never settles kindly
  always @(posedge clock) wobble <= ~wobble;
  assign wake_pin = drive & level | ~drive & (pull_up_enable | ~pull_down_enable & wobble);
endmodule // wkcfg_pins

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wkcfg_pkg::*;
  logic clock = 0, rst = 1, sleep_command = 0, measurement_enable = 0, other_wake_source_enabled = 0;
  logic first_timer_on = 0, second_timer_on = 0, measurement_switch, wake_request, spi_fail;
  logic restart_request, sleep_accept;
  logic [2:0] drive = 3'h7, level = 3'h0, wake_source_enable_reg = 3'h1, wake_event_clear = 3'h0, wake_pin;
  logic [2:0] wake_event_status_first, wake_pin_level_status, pull_up_enable, pull_down_enable;
  logic [5:0] wake_pull_control_reg = 6'h00, wake_filter_control_reg = 6'h00;
  wkcfg_mode_t op_mode = wkcfg_mode_normal;
  int fails = 0, compares = 0, cyc = 0;
  // pull code, measurement, mode, then expected pull-up, pull-down, switch
  logic [15:0] rows [6] = '{16'h0000, 16'h9044, 16'h642A, 16'hFC0E, 16'h9241, 16'h6688};
  wkcfg_core uut (.*);
  wkcfg_pins u_pins (.*);
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic slp(input logic m, input logic [2:0] exp);
    @(posedge clock);
    measurement_enable <= m;
    sleep_command <= 1;
    @(posedge clock);
    sleep_command <= 0;
    #1 chk({7'h0, spi_fail, restart_request, sleep_accept}, {7'h0, exp});
  endtask
  task automatic wk(input logic m, input logic [2:0] d, input logic [5:0] f, input logic [2:0] lv,
      input int lo, input int win, input logic [9:0] exp);
    logic [2:0] e;
    @(posedge clock);
    measurement_enable <= m;
    drive <= d;
    wake_filter_control_reg <= f;
    wake_source_enable_reg <= 3'h7;
    level <= lv;
    wake_event_clear <= 3'h7;
    @(posedge clock);
    wake_event_clear <= 3'h0;
    repeat (lo) @(posedge clock);
    #1 e = wake_event_status_first;
    for (int n = 0; n < win && wake_request !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk({e, wake_request, wake_event_status_first, wake_pin_level_status}, exp);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    #1 chk({2'h0, measurement_switch, pull_up_enable, pull_down_enable, spi_fail}, 10'h000);
    foreach (rows[i]) begin
      @(posedge clock);
      wake_pull_control_reg <= rows[i][15:10];
      measurement_enable <= rows[i][9];
      op_mode <= wkcfg_mode_t'(rows[i][8:7]);
      repeat (3) @(posedge clock);
      #1 chk({3'h0, pull_up_enable, pull_down_enable, measurement_switch}, {3'h0, rows[i][6:0]});
    end
    slp(1, 3'h6);
    slp(0, 3'h1);
    wk(0, 3'h7, 6'h00, 3'h4, 300, 40, 10'h064);
    wk(0, 3'h7, 6'h10, 3'h0, 1000, 400, 10'h060);
    // first input driven high while gated: no status, no request, level status frozen
    wk(1, 3'h7, 6'h00, 3'h1, 400, 1, 10'h000);
    // ungated again: first input's level status catches up, closed timer window hides the third
    wk(0, 3'h7, 6'h20, 3'h5, 400, 1, 10'h001);
    @(posedge clock);
    first_timer_on <= 1;
    wk(0, 3'h7, 6'h20, 3'h5, 300, 60, 10'h065);
    stop_test();
  end
endmodule // tb_top
bind wkcfg_core wkcfg_properties u_props (.*);
